// ### core/program_memory_addressing.sv
// Function
// - Each program location is 24 bits: lower 16-bit word, upper word top byte absent.
// - Lower word sits at the even address, upper word at the next odd one.
// - Program counter stays even and moves forward or back by two per location.
// - Addresses 0x000000 to 0x0001FF hold vectors only, never general code.
// - Any reset loads the default counter and fetches from the reset vector.
`timescale 1ns/100ps
module program_memory_addressing #(
  parameter int DEPTH = progmem_pkg::DEPTH_DEF
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_step_fwd,
  input wire logic i_step_back,
  input wire logic i_branch,
  input wire logic [progmem_pkg::ADDR_W-1:0] i_branch_addr,
  input wire logic i_tbl_rd,
  input wire logic [progmem_pkg::ADDR_W-1:0] i_tbl_addr,
  input wire logic i_wr_en,
  input wire logic [progmem_pkg::ADDR_W-1:0] i_wr_addr,
  input wire logic [progmem_pkg::LOC_W-1:0] i_wr_data,
  output logic [progmem_pkg::ADDR_W-1:0] o_pc,
  output logic o_running,
  output logic o_halted,
  output logic o_instr_valid,
  output logic [progmem_pkg::ADDR_W-1:0] o_instr_addr,
  output logic [progmem_pkg::LOC_W-1:0] o_instr,
  output logic o_tbl_valid,
  output logic [progmem_pkg::WORD_W-1:0] o_tbl_data,
  output logic o_vector_fault
);
  import progmem_pkg::*;

  pc_state_t state_q;
  pc_state_t state_d;
  logic [ADDR_W-1:0] pc_q;
  logic [ADDR_W-1:0] pc_d;
  logic [ADDR_W-1:0] next_fwd;
  logic [ADDR_W-1:0] next_back;
  logic [ADDR_W-1:0] vec_target;
  logic fwd_ok;
  logic back_ok;
  logic branch_ok;
  logic fault_d;
  logic fault_q;
  logic run_q;
  logic [ADDR_W-1:0] fetch_addr_q;
  logic tbl_pend_q;
  logic tbl_odd_q;

  prog_mem_if mem_bus ();

  prog_array #(.DEPTH(DEPTH)) u_array (
    .i_clock(i_clock),
    .bus(mem_bus)
  );

  // Candidate counter values; steps are always two so the counter stays even
  assign next_fwd = pc_q + PC_STEP;
  assign next_back = pc_q - PC_STEP;
  // Target word of the reset jump, forced onto a lower-word address
  assign vec_target = {mem_bus.fetch_data[ADDR_W-1:1], 1'b0};
  // Moves that would land inside the vector area are refused
  assign fwd_ok = (next_fwd >= VECTOR_END) && (next_fwd > pc_q);
  assign back_ok = (next_back >= VECTOR_END) && (next_back < pc_q);
  assign branch_ok = (i_branch_addr >= VECTOR_END) && !i_branch_addr[0];

  // Start-up walk: jump opcode, then its target, then run from the target
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    fault_d = 1'b0;
    case (state_q)
      ST_VEC_OP: begin
        state_d = ST_VEC_TGT;
      end
      ST_VEC_TGT: begin
        state_d = ST_LOAD;
      end
      ST_LOAD: begin
        // A target inside the vector area would run vectors as code: stop
        if (vec_target >= VECTOR_END) begin
          pc_d = vec_target;
          state_d = ST_RUN;
        end else begin
          fault_d = 1'b1;
          state_d = ST_HALT;
        end
      end
      ST_RUN: begin
        // Branch wins over a step in the same cycle
        if (i_branch) begin
          if (branch_ok) begin
            pc_d = i_branch_addr;
          end else begin
            fault_d = 1'b1;
          end
        end else if (i_step_fwd) begin
          if (fwd_ok) begin
            pc_d = next_fwd;
          end else begin
            fault_d = 1'b1;
          end
        end else if (i_step_back) begin
          if (back_ok) begin
            pc_d = next_back;
          end else begin
            fault_d = 1'b1;
          end
        end
      end
      ST_HALT: begin
        state_d = ST_HALT;
      end
      default: begin
        state_d = ST_HALT;
      end
    endcase
  end

  // State and counter; reset always restarts the vector walk
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_q <= ST_VEC_OP;
      pc_q <= RESET_VECTOR;
      fault_q <= 1'b0;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
      fault_q <= fault_d;
    end
  end

  // Fetch address: the target word is read during the second start-up step
  assign mem_bus.fetch_addr = (state_q == ST_VEC_TGT) ? TARGET_LOC : pc_q;

  // Table read port and program load port pass straight to the array
  assign mem_bus.tbl_addr = i_tbl_addr;
  assign mem_bus.wr_en = i_wr_en;
  assign mem_bus.wr_addr = i_wr_addr;
  assign mem_bus.wr_data = i_wr_data;

  // Tag fetched data with its address, registered on the same edge as the array read
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      run_q <= 1'b0;
      fetch_addr_q <= RESET_VECTOR;
    end else begin
      run_q <= (state_q == ST_RUN);
      fetch_addr_q <= mem_bus.fetch_addr;
    end
  end

  // Remember which half of the location the table read asked for
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      tbl_pend_q <= 1'b0;
      tbl_odd_q <= 1'b0;
    end else begin
      tbl_pend_q <= i_tbl_rd;
      tbl_odd_q <= i_tbl_addr[0];
    end
  end

  // Outputs; the instruction path is 24 bits, the table path word wide
  assign o_pc = pc_q;
  assign o_running = (state_q == ST_RUN);
  assign o_halted = (state_q == ST_HALT);
  assign o_instr_valid = run_q;
  assign o_instr_addr = fetch_addr_q;
  assign o_instr = mem_bus.fetch_data;
  assign o_tbl_valid = tbl_pend_q;
  assign o_vector_fault = fault_q;
  // Odd address gives the upper word with its missing byte read as zero
  always_comb begin
    if (!tbl_pend_q) begin
      o_tbl_data = '0;
    end else if (tbl_odd_q) begin
      o_tbl_data = {UPPER_PAD, mem_bus.tbl_data[LOC_W-1:WORD_W]};
    end else begin
      o_tbl_data = mem_bus.tbl_data[WORD_W-1:0];
    end
  end

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence vec_walk_s;
    state_q == ST_VEC_OP ##1 state_q == ST_VEC_TGT ##1 state_q == ST_LOAD;
  endsequence

  sequence fwd_req_s;
    o_running && !i_branch && i_step_fwd && fwd_ok;
  endsequence

  sequence back_req_s;
    o_running && !i_branch && !i_step_fwd && i_step_back && back_ok;
  endsequence

  reset_vector_a: assert property (
    $fell(i_sys_rst) |-> pc_q == RESET_VECTOR ##0 vec_walk_s)
    else $error("reset did not start the vector walk at the reset vector");

  target_fetch_a: assert property (
    state_q == ST_VEC_TGT |-> mem_bus.fetch_addr == TARGET_LOC ##1
      (state_q == ST_LOAD && fetch_addr_q == TARGET_LOC))
    else $error("jump target not read from its word");

  vector_load_a: assert property (
    state_q == ST_LOAD && vec_target >= VECTOR_END |=>
      o_running && o_pc == $past(vec_target))
    else $error("counter not loaded from the reset jump target");

  pc_even_a: assert property (
    o_pc[0] == 1'b0)
    else $error("program counter left a lower-word address");

  step_fwd_a: assert property (
    fwd_req_s |=> o_pc == $past(o_pc) + PC_STEP)
    else $error("forward step was not two");

  step_back_a: assert property (
    back_req_s |=> o_pc == $past(o_pc) - PC_STEP)
    else $error("backward step was not two");

  vector_guard_a: assert property (
    o_running |-> o_pc >= VECTOR_END)
    else $error("counter ran inside the vector area");

  bad_branch_a: assert property (
    o_running && i_branch && !branch_ok |=> o_vector_fault && $stable(o_pc))
    else $error("branch into vector area was not refused");

  upper_zero_a: assert property (
    i_tbl_rd && i_tbl_addr[0] |=> o_tbl_valid && o_tbl_data[15:8] == 8'h00)
    else $error("missing upper byte read as non-zero");

  word_pair_a: assert property (
    i_tbl_rd && !i_tbl_addr[0] |=> o_tbl_data == mem_bus.tbl_data[WORD_W-1:0])
    else $error("even address did not give the lower word");
endmodule : program_memory_addressing

// ### core/progmem_pkg.sv
package progmem_pkg;
  // Address and location geometry
  localparam int ADDR_W = 24;
  localparam int LOC_W = 24;
  localparam int WORD_W = 16;
  localparam int UPPER_W = 8;
  localparam int DEPTH_DEF = 1024;
  // Key addresses in program space, the counter step and the upper pad byte
  localparam logic [23:0] RESET_VECTOR = 24'h00_0000;
  localparam logic [23:0] TARGET_LOC = 24'h00_0002;
  localparam logic [23:0] VECTOR_END = 24'h00_0200;
  localparam logic [23:0] PC_STEP = 24'h00_0002;
  localparam logic [7:0] UPPER_PAD = 8'h00;
  // Start-up and run states
  typedef enum logic [2:0] {
    ST_VEC_OP = 3'b000,
    ST_VEC_TGT = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN = 3'b011,
    ST_HALT = 3'b100
  } pc_state_t;
endpackage : progmem_pkg

// ### core/prog_mem_if.sv
`timescale 1ns/100ps
interface prog_mem_if;
  import progmem_pkg::*;
  logic [ADDR_W-1:0] fetch_addr;
  logic [LOC_W-1:0] fetch_data;
  logic [ADDR_W-1:0] tbl_addr;
  logic [LOC_W-1:0] tbl_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [LOC_W-1:0] wr_data;
  modport core (output fetch_addr, output tbl_addr, output wr_en, output wr_addr,
    output wr_data, input fetch_data, input tbl_data);
  modport mem (input fetch_addr, input tbl_addr, input wr_en, input wr_addr,
    input wr_data, output fetch_data, output tbl_data);
endinterface : prog_mem_if

// ### core/prog_array.sv
`timescale 1ns/100ps
module prog_array #(
  parameter int DEPTH = progmem_pkg::DEPTH_DEF
) (
  input wire logic i_clock,
  prog_mem_if.mem bus
);
  import progmem_pkg::*;
  localparam int IDX_W = $clog2(DEPTH);

  logic [LOC_W-1:0] mem_q [DEPTH];

  // One location per even address; odd addresses fold onto the same entry
  function automatic logic hit(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:1] < (ADDR_W-1)'(DEPTH));
  endfunction : hit

  function automatic logic [IDX_W-1:0] idx(input logic [ADDR_W-1:0] a);
    return a[IDX_W:1];
  endfunction : idx

  // Program load port
  always_ff @(posedge i_clock) begin
    if (bus.wr_en && hit(bus.wr_addr)) begin
      mem_q[idx(bus.wr_addr)] <= bus.wr_data;
    end
  end

  // Registered reads; out of range reads give zero so no undefined bits leak
  always_ff @(posedge i_clock) begin
    bus.fetch_data <= hit(bus.fetch_addr) ? mem_q[idx(bus.fetch_addr)] : '0;
    bus.tbl_data <= hit(bus.tbl_addr) ? mem_q[idx(bus.tbl_addr)] : '0;
  end
endmodule : prog_array

// ### sim/loader_model.sv
`timescale 1ns/100ps
module loader_model (
  input wire logic i_clock,
  output logic o_wr_en,
  output logic [23:0] o_wr_addr,
  output logic [23:0] o_wr_data
);
  // Arbitrary opcode value; the block never decodes it
  localparam logic [23:0] JUMP_OP = 24'h04_0000;
  // Idle until a load is commanded
  initial begin
    o_wr_en = 1'b0;
    o_wr_addr = 24'h00_0000;
    o_wr_data = 24'h00_0000;
  end
  // One location every two cycles; released lines show the inverse, not the old value
  task automatic put(input logic [23:0] a, input logic [23:0] d);
    @(negedge i_clock);
    o_wr_en = 1'b1;
    o_wr_addr = a;
    o_wr_data = d;
    @(negedge i_clock);
    o_wr_en = 1'b0;
    o_wr_addr = ~a;
    o_wr_data = ~d;
  endtask : put
  // Jump at the vector, its target next, then four code words at the target
  task automatic load(input logic [23:0] tgt);
    put(24'h00_0000, JUMP_OP);
    put(24'h00_0002, tgt);
    for (int i = 0; i < 4; i++) begin
      put(tgt + 24'(2 * i), {8'h5A, tgt[15:0] + 16'(2 * i)});
    end
  endtask : load
endmodule : loader_model

// ### sim/tb.sv
`timescale 1ns/100ps
module tb;
  import progmem_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_step_fwd = 1'b0;
  logic i_step_back = 1'b0;
  logic i_branch = 1'b0;
  logic [23:0] i_branch_addr = 24'h00_0000;
  logic i_tbl_rd = 1'b0;
  logic [23:0] i_tbl_addr = 24'h00_0000;
  logic i_wr_en, o_running, o_halted, o_instr_valid, o_tbl_valid, o_vector_fault, f;
  logic [23:0] i_wr_addr, i_wr_data, o_pc, o_instr_addr, o_instr;
  logic [15:0] o_tbl_data;
  int num_errors = 0;
  int cmp_count = 0;
  // 200 MHz
  always #2.5 i_clock = ~i_clock;
  program_memory_addressing program_memory_addressing_i (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_step_fwd(i_step_fwd), .i_step_back(i_step_back),
    .i_branch(i_branch), .i_branch_addr(i_branch_addr), .i_tbl_rd(i_tbl_rd),
    .i_tbl_addr(i_tbl_addr), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr),
    .i_wr_data(i_wr_data), .o_pc(o_pc), .o_running(o_running), .o_halted(o_halted),
    .o_instr_valid(o_instr_valid), .o_instr_addr(o_instr_addr), .o_instr(o_instr),
    .o_tbl_valid(o_tbl_valid), .o_tbl_data(o_tbl_data), .o_vector_fault(o_vector_fault));
  loader_model loader_model_i (.i_clock(i_clock), .o_wr_en(i_wr_en),
    .o_wr_addr(i_wr_addr), .o_wr_data(i_wr_data));
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // Zero extension keeps an unknown bit visible to the case compare
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Program loaded under reset, then a bounded wait for the start-up jump
  task automatic boot(input logic [23:0] tgt);
    int n;
    i_sys_rst = 1'b1;
    loader_model_i.load(tgt);
    repeat (8) @(negedge i_clock);
    chk("pc in reset", 24'h00_0000, o_pc);
    i_sys_rst = 1'b0;
    for (n = 0; n < 20 && o_running !== 1'b1 && o_halted !== 1'b1; n++) begin
      @(negedge i_clock);
    end
    if (n == 20) begin
      num_errors++;
      stop_test();
    end
  endtask : boot
  // One move request held for one edge; fault may show one edge late
  task automatic move(input logic [2:0] m, input logic [23:0] a);
    @(negedge i_clock);
    {i_branch, i_step_fwd, i_step_back} = m;
    i_branch_addr = a;
    @(negedge i_clock);
    {i_branch, i_step_fwd, i_step_back} = 3'b000;
    f = o_vector_fault;
    @(negedge i_clock);
    f = f | o_vector_fault;
  endtask : move
  task automatic trd(input logic [23:0] a, input logic [15:0] exp);
    @(negedge i_clock);
    i_tbl_rd = 1'b1;
    i_tbl_addr = a;
    @(negedge i_clock);
    i_tbl_rd = 1'b0;
    chk("tbl valid", 24'h00_0001, {23'h0, o_tbl_valid});
    chk("tbl data", {8'h00, exp}, {8'h00, o_tbl_data});
  endtask : trd
  task automatic t_boot();
    boot(24'h00_0400);
    chk("boot pc", 24'h00_0400, o_pc);
    chk("running", 24'h00_0001, {23'h0, o_running});
    $display("test boot done");
  endtask : t_boot
  task automatic t_step();
    move(3'b010, 24'h00_0000);
    chk("fwd pc", 24'h00_0402, o_pc);
    chk("instr addr", 24'h00_0402, o_instr_addr);
    chk("instr", 24'h5A_0402, o_instr);
    chk("instr valid", 24'h00_0001, {23'h0, o_instr_valid});
    // Back to back: two forward then one back
    @(negedge i_clock);
    i_step_fwd = 1'b1;
    repeat (2) @(negedge i_clock);
    i_step_fwd = 1'b0;
    i_step_back = 1'b1;
    @(negedge i_clock);
    i_step_back = 1'b0;
    chk("b2b pc", 24'h00_0404, o_pc);
    $display("test step done");
  endtask : t_step
  task automatic t_refuse();
    move(3'b100, 24'h00_0200);
    chk("branch edge", 24'h00_0200, o_pc);
    chk("edge fault", 24'h00_0000, {23'h0, f});
    move(3'b001, 24'h00_0000);
    chk("back fault", 24'h00_0001, {23'h0, f});
    chk("back pc", 24'h00_0200, o_pc);
    move(3'b100, 24'h00_0401);
    chk("odd fault", 24'h00_0001, {23'h0, f});
    chk("odd pc", 24'h00_0200, o_pc);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_table();
    trd(24'h00_0002, 16'h0400);
    trd(24'h00_0003, 16'h0000);
    trd(24'h00_0405, 16'h005A);
    trd(24'h00_0404, 16'h0404);
    // Beyond the array the upper word still reads as zero
    trd(24'h00_0801, 16'h0000);
    $display("test table done");
  endtask : t_table
  task automatic t_halt();
    boot(24'h00_0100);
    // The refused start-up target pulses the fault in the cycle the halt appears
    chk("load fault", 24'h00_0001, {23'h0, o_vector_fault});
    chk("halt instr valid", 24'h00_0000, {23'h0, o_instr_valid});
    chk("halted", 24'h00_0001, {23'h0, o_halted});
    chk("not running", 24'h00_0000, {23'h0, o_running});
    $display("test halt done");
  endtask : t_halt
  initial begin
    t_boot();
    t_step();
    t_refuse();
    t_table();
    t_halt();
    stop_test();
  end
endmodule : tb
